// ===== bcd_decoder.sv
// Purpose: Decodes output-image blocks and builds the error-list reply.
// Assumes: Word 0 of each block is flagged by wordFirst; words arrive in order.
// Notes: Control blocks past their valid range are dropped without side effects.
// Functional notes
// - Write block: identifier then chunk-sized payload.
// - Identifier selects the database area written.
// - Identifiers above 9900 are control functions.
// - Enable block sets listed flags to -1.
// - One-shot command clears its flag after running.
// - Enable: count in word 2, numbers follow.
// - Word 1 selects port 0 to 3.
// - Enable and disable blocks get no reply.
// - Disable block writes 0 to listed flags.
// - Disable: count 1 to 60, numbers follow.
// - Error request: port, count 1 to 50.
// - Word 3 holds zero-based start index.
// - Reply header: id, next block, port, count, start.
// - Reply words 5 to 54 carry last errors.
// - Reply only for a valid request.
// - Keep error entry per command per port.
// - Cycle read blocks, request next write block.
// - Identifiers -1 and 0 carry no data.
// - Identifier 9998 triggers a warm restart.
module bcd_decoder
  import bcd_pkg::*;
#(
  parameter int CHUNK_WORDS = 60,
  parameter int WRITE_BLOCKS = 20,
  parameter int READ_BLOCKS = 20,
  parameter int CMD_LIST_LEN = 99,
  parameter int DB_AW = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wordValid,
  input wire logic wordFirst,
  input wire logic [15:0] wordData,
  input wire logic cmdDone,
  input wire logic [1:0] donePort,
  input wire logic [6:0] doneCmd,
  input wire logic [2:0] doneCode,
  input wire logic errWrEn,
  input wire logic [1:0] errPort,
  input wire logic [6:0] errCmd,
  input wire logic [15:0] errValue,
  output logic dbWrEn,
  output logic [DB_AW-1:0] dbWrAddr,
  output logic [15:0] dbWrData,
  output logic flagWrEn,
  output logic [1:0] flagPort,
  output logic [6:0] flagCmd,
  output logic [15:0] flagData,
  output logic replyValid,
  output logic [15:0] replyWord,
  output logic replyLast,
  output logic warmRestart,
  output logic blockDone,
  output logic [7:0] inputChunkIndex,
  output logic [7:0] outputChunkRequest
);

  // Parameters the counters and address arithmetic cannot serve are refused.
  if (!(CHUNK_WORDS == 60 || CHUNK_WORDS == 120 || CHUNK_WORDS == 240)) begin : g_chk_chunk
    $error("CHUNK_WORDS must be 60, 120 or 240");
  end
  if (CMD_LIST_LEN < 1 || CMD_LIST_LEN > CMDS_PER_PORT) begin : g_chk_len
    $error("CMD_LIST_LEN must be 1 to 99");
  end
  if (WRITE_BLOCKS < 1 || WRITE_BLOCKS > 255
      || READ_BLOCKS < 1 || READ_BLOCKS > 255) begin : g_chk_blk
    $error("block counts must be 1 to 255");
  end
  if (WRITE_BLOCKS * CHUNK_WORDS > (1 << DB_AW)) begin : g_chk_db
    $error("DB_AW too small for the write area");
  end

  // Decoder state.
  bcd_kind_t kind_reg, kind_next;
  logic inBlk_reg, inBlk_next;
  logic [7:0] wIdx_reg, wIdx_next;
  logic [DB_AW-1:0] base_reg, base_next;
  logic [1:0] port_reg, port_next;
  logic [5:0] count_reg, count_next;
  logic [6:0] start_reg, start_next;
  logic ctlOk_reg, ctlOk_next;
  logic dbWrEn_next, warm_next, blockDone_next;
  logic [DB_AW-1:0] dbWrAddr_next;
  logic [15:0] dbWrData_next;
  logic [7:0] readIdx_next, reqIdx_next;
  logic [7:0] curIdx;
  logic blockEnd, repGo, blkWrEn;
  logic [6:0] blkWrCmd;
  logic [16:0] startSum;

  function automatic bcd_kind_t classify(input logic [15:0] id);
    if (id == ID_NULL_NEG || id == ID_NULL_ZERO) begin
      return KIND_NULL;
    end
    if (id == ID_ENABLE) begin
      return KIND_ENABLE;
    end
    if (id == ID_DISABLE) begin
      return KIND_DISABLE;
    end
    if (id == ID_ERRLIST) begin
      return KIND_ERRLIST;
    end
    if (id == ID_WARM) begin
      return KIND_WARM;
    end
    if (id > ID_SPECIAL_BASE || id > 16'(WRITE_BLOCKS)) begin
      return KIND_IGNORE;
    end
    return KIND_DATA;
  endfunction : classify

  // Block decode: word counting, field capture and per-word actions.
  always_comb begin
    kind_next = kind_reg;
    inBlk_next = inBlk_reg;
    wIdx_next = wIdx_reg;
    base_next = base_reg;
    port_next = port_reg;
    count_next = count_reg;
    start_next = start_reg;
    ctlOk_next = ctlOk_reg;
    dbWrEn_next = 1'b0;
    dbWrAddr_next = dbWrAddr;
    dbWrData_next = dbWrData;
    warm_next = 1'b0;
    blockDone_next = 1'b0;
    readIdx_next = inputChunkIndex;
    reqIdx_next = outputChunkRequest;
    curIdx = wIdx_reg + 8'h01;
    blockEnd = 1'b0;
    repGo = 1'b0;
    blkWrEn = 1'b0;
    blkWrCmd = wordData[6:0];
    startSum = {1'b0, wordData} + {11'h000, count_reg};
    if (wordValid && wordFirst) begin
      wIdx_next = 8'h00;
      inBlk_next = 1'b1;
      kind_next = classify(wordData);
      base_next = DB_AW'((32'(wordData) - 32'd1) * 32'(CHUNK_WORDS));
      ctlOk_next = 1'b0;
    end else if (wordValid && inBlk_reg) begin
      wIdx_next = curIdx;
      unique case (kind_reg)
        KIND_DATA: begin
          dbWrEn_next = 1'b1;
          dbWrAddr_next = base_reg + DB_AW'(curIdx - 8'h01);
          dbWrData_next = wordData;
        end
        KIND_ENABLE, KIND_DISABLE, KIND_ERRLIST: begin
          if (curIdx == W_PORT) begin
            port_next = wordData[1:0];
            ctlOk_next = (wordData <= MAX_PORT);
          end else if (curIdx == W_COUNT) begin
            count_next = wordData[5:0];
            if (kind_reg == KIND_ERRLIST) begin
              ctlOk_next = ctlOk_reg && wordData != 16'h0000 && wordData <= MAX_ERR_COUNT
                && wordData <= 16'(CMD_LIST_LEN);
            end else begin
              ctlOk_next = ctlOk_reg && wordData != 16'h0000
                && wordData <= MAX_EN_COUNT;
            end
          end else if (kind_reg == KIND_ERRLIST) begin
            if (curIdx == W_START) begin
              start_next = wordData[6:0];
              ctlOk_next = ctlOk_reg && startSum <= 17'(CMD_LIST_LEN);
            end
          end else if (ctlOk_reg && curIdx < W_FIRST_CMD + {2'b00, count_reg}
              && wordData < 16'(CMD_LIST_LEN)) begin
            blkWrEn = 1'b1;
          end
        end
        default: begin
        end
      endcase
      if (curIdx == 8'(CHUNK_WORDS)) begin
        blockEnd = 1'b1;
        inBlk_next = 1'b0;
        blockDone_next = 1'b1;
        warm_next = (kind_reg == KIND_WARM);
        repGo = (kind_reg == KIND_ERRLIST) && ctlOk_reg;
        // Read blocks rotate and the next write block is requested in turn.
        readIdx_next = (inputChunkIndex >= 8'(READ_BLOCKS)) ? RST_CHUNK_IDX
          : inputChunkIndex + 8'h01;
        reqIdx_next = (outputChunkRequest >= 8'(WRITE_BLOCKS)) ? RST_CHUNK_IDX
          : outputChunkRequest + 8'h01;
      end
    end
  end

  // Decoder registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kind_reg <= KIND_IGNORE;
      inBlk_reg <= 1'b0;
      wIdx_reg <= 8'h00;
      base_reg <= '0;
      port_reg <= 2'h0;
      count_reg <= 6'h00;
      start_reg <= 7'h00;
      ctlOk_reg <= 1'b0;
      dbWrEn <= 1'b0;
      dbWrAddr <= '0;
      dbWrData <= RST_WORD;
      warmRestart <= 1'b0;
      blockDone <= 1'b0;
      inputChunkIndex <= RST_CHUNK_IDX;
      outputChunkRequest <= RST_CHUNK_IDX;
    end else begin
      kind_reg <= kind_next;
      inBlk_reg <= inBlk_next;
      wIdx_reg <= wIdx_next;
      base_reg <= base_next;
      port_reg <= port_next;
      count_reg <= count_next;
      start_reg <= start_next;
      ctlOk_reg <= ctlOk_next;
      dbWrEn <= dbWrEn_next;
      dbWrAddr <= dbWrAddr_next;
      dbWrData <= dbWrData_next;
      warmRestart <= warm_next;
      blockDone <= blockDone_next;
      inputChunkIndex <= readIdx_next;
      outputChunkRequest <= reqIdx_next;
    end
  end

  // Flag writes. Block words cannot be stalled, so a one-shot clear that
  // collides with one waits in a single pending slot.
  logic pendV_reg, pendV_next;
  logic [1:0] pendPort_reg, pendPort_next;
  logic [6:0] pendCmd_reg, pendCmd_next;
  logic flagWrEn_next;
  logic [1:0] flagPort_next;
  logic [6:0] flagCmd_next;
  logic [15:0] flagData_next;
  logic doneOne;

  always_comb begin
    doneOne = cmdDone && doneCode == CODE_ONESHOT;
    pendV_next = pendV_reg;
    pendPort_next = pendPort_reg;
    pendCmd_next = pendCmd_reg;
    flagWrEn_next = 1'b0;
    flagPort_next = flagPort;
    flagCmd_next = flagCmd;
    flagData_next = flagData;
    if (blkWrEn) begin
      flagWrEn_next = 1'b1;
      flagPort_next = port_reg;
      flagCmd_next = blkWrCmd;
      flagData_next = (kind_reg == KIND_ENABLE) ? FLAG_ON : FLAG_OFF;
      if (doneOne) begin
        pendV_next = 1'b1;
        pendPort_next = donePort;
        pendCmd_next = doneCmd;
      end
    end else if (pendV_reg || doneOne) begin
      flagWrEn_next = 1'b1;
      flagPort_next = pendV_reg ? pendPort_reg : donePort;
      flagCmd_next = pendV_reg ? pendCmd_reg : doneCmd;
      flagData_next = FLAG_OFF;
      pendV_next = pendV_reg && doneOne;
      pendPort_next = donePort;
      pendCmd_next = doneCmd;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pendV_reg <= 1'b0;
      pendPort_reg <= 2'h0;
      pendCmd_reg <= 7'h00;
      flagWrEn <= 1'b0;
      flagPort <= 2'h0;
      flagCmd <= 7'h00;
      flagData <= RST_WORD;
    end else begin
      pendV_reg <= pendV_next;
      pendPort_reg <= pendPort_next;
      pendCmd_reg <= pendCmd_next;
      flagWrEn <= flagWrEn_next;
      flagPort <= flagPort_next;
      flagCmd <= flagCmd_next;
      flagData <= flagData_next;
    end
  end

  // Error store: port in the upper bits, command in the lower seven.
  logic [8:0] memRdAddr;
  logic [15:0] memRdData;

  bcd_err_mem #(.AW(9), .DW(16)) u_err_mem (
    .clk(clk),
    .wrEn(errWrEn),
    .wrAddr({errPort, errCmd}),
    .wrData(errValue),
    .rdAddr(memRdAddr),
    .rdData(memRdData)
  );

  // Reply sender. Parameters are captured so a new block may arrive meanwhile;
  // a request arriving while a reply is running is dropped.
  bcd_rep_t rep_reg, rep_next;
  logic [5:0] repIdx_reg, repIdx_next;
  logic [1:0] repPort_reg, repPort_next;
  logic [5:0] repCount_reg, repCount_next;
  logic [6:0] repStart_reg, repStart_next;
  logic replyValid_next, replyLast_next;
  logic [15:0] replyWord_next;
  logic [5:0] errOff;

  always_comb begin
    rep_next = rep_reg;
    repIdx_next = repIdx_reg;
    repPort_next = repPort_reg;
    repCount_next = repCount_reg;
    repStart_next = repStart_reg;
    replyValid_next = 1'b0;
    replyLast_next = 1'b0;
    replyWord_next = replyWord;
    errOff = repIdx_reg - R_ERR_FIRST;
    // Address runs one word ahead to cover the store's read register.
    memRdAddr = {repPort_reg, repStart_reg + 7'(repIdx_reg - 6'h04)};
    unique case (rep_reg)
      RP_IDLE: begin
        if (repGo) begin
          rep_next = RP_SEND;
          repIdx_next = 6'h00;
          repPort_next = port_reg;
          repCount_next = count_reg;
          repStart_next = start_reg;
        end
      end
      RP_SEND: begin
        replyValid_next = 1'b1;
        replyLast_next = (repIdx_reg == R_LAST);
        if (repIdx_reg == R_ID) begin
          replyWord_next = ID_ERRLIST;
        end else if (repIdx_reg == R_NEXT) begin
          replyWord_next = {8'h00, outputChunkRequest};
        end else if (repIdx_reg == R_PORT) begin
          replyWord_next = {14'h0000, repPort_reg};
        end else if (repIdx_reg == R_COUNT) begin
          replyWord_next = {10'h000, repCount_reg};
        end else if (repIdx_reg == R_START) begin
          replyWord_next = {9'h000, repStart_reg};
        end else if (repIdx_reg >= R_ERR_FIRST && errOff < repCount_reg) begin
          replyWord_next = memRdData;
        end else begin
          replyWord_next = RST_WORD;
        end
        repIdx_next = repIdx_reg + 6'h01;
        if (repIdx_reg == R_LAST) begin
          rep_next = RP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rep_reg <= RP_IDLE;
      repIdx_reg <= 6'h00;
      repPort_reg <= 2'h0;
      repCount_reg <= 6'h00;
      repStart_reg <= 7'h00;
      replyValid <= 1'b0;
      replyLast <= 1'b0;
      replyWord <= RST_WORD;
    end else begin
      rep_reg <= rep_next;
      repIdx_reg <= repIdx_next;
      repPort_reg <= repPort_next;
      repCount_reg <= repCount_next;
      repStart_reg <= repStart_next;
      replyValid <= replyValid_next;
      replyLast <= replyLast_next;
      replyWord <= replyWord_next;
    end
  end

  // Checks on the decoder's own outputs.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_head;
    replyValid && replyWord == ID_ERRLIST ##1 replyValid ##1 replyValid
      && replyWord[1:0] == $past(port_reg, 3);
  endsequence

  a_db_in_area: assert property (dbWrEn |-> dbWrAddr < DB_AW'(WRITE_BLOCKS * CHUNK_WORDS))
    else $error("database write outside the write area");
  a_special_no_db: assert property (wordValid && !wordFirst && inBlk_reg
      && kind_reg != KIND_DATA |=> !dbWrEn)
    else $error("control or null block wrote the database");
  a_enable_sets: assert property (blkWrEn && kind_reg == KIND_ENABLE
      |=> flagWrEn && flagData == FLAG_ON && flagCmd == $past(wordData[6:0]))
    else $error("enable block did not set the flag");
  a_disable_clears: assert property (blkWrEn && kind_reg == KIND_DISABLE
      |=> flagWrEn && flagData == FLAG_OFF && flagPort == $past(port_reg))
    else $error("disable block did not clear the flag");
  a_oneshot_clear: assert property (doneOne && !blkWrEn && !pendV_reg
      |=> flagWrEn && flagData == FLAG_OFF && flagCmd == $past(doneCmd))
    else $error("one-shot command not cleared");
  a_no_ctl_reply: assert property (blockEnd && rep_reg == RP_IDLE
      && (kind_reg == KIND_ENABLE || kind_reg == KIND_DISABLE) |=> ##1 !replyValid)
    else $error("reply produced for enable or disable block");
  a_bad_req_quiet: assert property (blockEnd && kind_reg == KIND_ERRLIST && !ctlOk_reg
      && rep_reg == RP_IDLE |=> ##1 !replyValid)
    else $error("reply produced for invalid request");
  a_reply_header: assert property (repGo && rep_reg == RP_IDLE |=> ##1 s_head)
    else $error("reply header wrong");
  a_reply_length: assert property (replyLast |-> replyValid && $past(replyValid, 63)
      && !$past(replyValid, 64))
    else $error("reply is not 64 words");
  a_warm_pulse: assert property (blockEnd && kind_reg == KIND_WARM
      |=> warmRestart ##1 !warmRestart)
    else $error("warm restart pulse missing");
  // A one-shot clear may legally land right after a null block, so it is excluded.
  a_null_no_data: assert property (blockEnd && kind_reg == KIND_NULL && !doneOne
      && !pendV_reg |=> !dbWrEn && !flagWrEn)
    else $error("null block carried data");

endmodule : bcd_decoder

// ===== bcd_err_mem.sv
// Purpose: Last-error store, one word per command per port.
// Assumes: One write and one read port on the same clock.
// Notes: Read data comes out of a register, one cycle after the address.
module bcd_err_mem #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array: the host only reads entries that have been written.
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule : bcd_err_mem

// ===== bcd_host_model.sv
// Purpose: Behavioural host controller that writes output-image blocks word by word.
// Assumes: One word per clock when offered; a slow host leaves random gaps.
// Notes: Between words the data lines toggle so a stale word never looks offered.
module bcd_host_model
  import bcd_pkg::*;
#(
  parameter int CHUNK = 60
) (
  input wire logic clk,
  output logic wordValid,
  output logic wordFirst,
  output logic [15:0] wordData
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle lines before the first block.
  initial begin
    wordValid = 1'b0;
    wordFirst = 1'b0;
    wordData = 16'h0000;
  end

  // Sends the identifier then exactly CHUNK payload words, in order.
  task automatic send(input logic [15:0] blk [0:CHUNK], input logic slow);
    int i;
    i = 0;
    while (i <= CHUNK) begin
      @(posedge clk);
      #1;
      if (slow && ($urandom % 3 == 0)) begin
        wordValid = 1'b0;
        wordFirst = 1'b0;
        wordData = ~wordData;
      end else begin
        wordValid = 1'b1;
        wordFirst = (i == 0);
        wordData = blk[i];
        i++;
      end
    end
    @(posedge clk);
    #1;
    wordValid = 1'b0;
    wordFirst = 1'b0;
    wordData = ~wordData;
  endtask : send
endmodule : bcd_host_model

// ===== bcd_pkg.sv
// Purpose: Shared constants and types for the backplane control block decoder.
// Assumes: 16-bit backplane words, one word per clock when a word is offered.
// Notes: Identifier values are the decimal block codes written in hexadecimal.
package bcd_pkg;

  // Block identifiers seen in word 0 of an output-image block.
  localparam logic [15:0] ID_NULL_NEG = 16'hFFFF;
  localparam logic [15:0] ID_NULL_ZERO = 16'h0000;
  localparam logic [15:0] ID_SPECIAL_BASE = 16'h26AC;
  localparam logic [15:0] ID_ENABLE = 16'h26AE;
  localparam logic [15:0] ID_DISABLE = 16'h26AF;
  localparam logic [15:0] ID_ERRLIST = 16'h26DE;
  localparam logic [15:0] ID_WARM = 16'h270E;

  // Word positions inside control blocks and the error-list reply.
  localparam logic [7:0] W_PORT = 8'h01;
  localparam logic [7:0] W_COUNT = 8'h02;
  localparam logic [7:0] W_FIRST_CMD = 8'h03;
  localparam logic [7:0] W_START = 8'h03;
  localparam logic [5:0] R_ID = 6'h00;
  localparam logic [5:0] R_NEXT = 6'h01;
  localparam logic [5:0] R_PORT = 6'h02;
  localparam logic [5:0] R_COUNT = 6'h03;
  localparam logic [5:0] R_START = 6'h04;
  localparam logic [5:0] R_ERR_FIRST = 6'h05;
  localparam logic [5:0] R_LAST = 6'h3F;

  // Limits of control-block fields.
  localparam logic [15:0] MAX_PORT = 16'h0003;
  localparam logic [15:0] MAX_EN_COUNT = 16'h003C;
  localparam logic [15:0] MAX_ERR_COUNT = 16'h0032;
  localparam int CMDS_PER_PORT = 99;

  // Enable flag values and the one-shot enable code.
  localparam logic [15:0] FLAG_ON = 16'hFFFF;
  localparam logic [15:0] FLAG_OFF = 16'h0000;
  localparam logic [2:0] CODE_ONESHOT = 3'h5;

  // Values after reset.
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_CHUNK_IDX = 8'h01;

  // Kind of the block currently being received.
  typedef enum logic [2:0] {
    KIND_IGNORE = 3'b000,
    KIND_NULL = 3'b001,
    KIND_DATA = 3'b010,
    KIND_ENABLE = 3'b011,
    KIND_DISABLE = 3'b100,
    KIND_ERRLIST = 3'b101,
    KIND_WARM = 3'b110
  } bcd_kind_t;

  // Reply sender state.
  typedef enum logic {
    RP_IDLE = 1'b0,
    RP_SEND = 1'b1
  } bcd_rep_t;

endpackage : bcd_pkg

// ===== tb.sv
// Purpose: Self-checking bench for the control block decoder.
// Assumes: Default chunk of 60 words, 20 read and write blocks, 99 commands.
// Notes: A monitor collects every output event; each test compares the lists.
module tb
  import bcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CHUNK = 60;
  localparam int WB = 20;
  localparam int LEN = 99;
  logic clk, nrst, wordValid, wordFirst, cmdDone, errWrEn;
  logic [15:0] wordData, errValue;
  logic [1:0] donePort, errPort;
  logic [6:0] doneCmd, errCmd;
  logic [2:0] doneCode;
  logic dbWrEn, flagWrEn, replyValid, replyLast, warmRestart, blockDone;
  logic [15:0] dbWrAddr, dbWrData, flagData, replyWord;
  logic [1:0] flagPort;
  logic [6:0] flagCmd;
  logic [7:0] inputChunkIndex, outputChunkRequest, expReq;
  logic [15:0] blk [0:CHUNK];
  logic [15:0] errMem [0:3][0:98];
  logic [31:0] dbQ[$], flagQ[$], expF[$];
  logic [15:0] repQ[$];
  int warmN, doneN, lastAt, bad_count, comparisons, id, p, cnt, st, c;
  int bid[6] = '{ID_ENABLE, ID_ENABLE, ID_DISABLE, ID_ERRLIST, ID_ERRLIST, ID_ERRLIST};
  int bp[6] = '{4, 0, 1, 2, 0, 0};
  int bc[6] = '{1, 0, 61, 51, 0, 50};
  int bs[6] = '{0, 0, 0, 0, 0, 50};
  int ign[4] = '{ID_NULL_NEG, ID_NULL_ZERO, 16'h0015, 16'h270F};

  bcd_host_model #(.CHUNK(CHUNK)) host (.clk(clk), .wordValid(wordValid),
    .wordFirst(wordFirst), .wordData(wordData));

  bcd_decoder #(.CHUNK_WORDS(CHUNK), .WRITE_BLOCKS(WB), .READ_BLOCKS(20),
    .CMD_LIST_LEN(LEN), .DB_AW(16)) dut (.clk(clk), .nrst(nrst),
    .wordValid(wordValid), .wordFirst(wordFirst), .wordData(wordData),
    .cmdDone(cmdDone), .donePort(donePort), .doneCmd(doneCmd), .doneCode(doneCode),
    .errWrEn(errWrEn), .errPort(errPort), .errCmd(errCmd), .errValue(errValue),
    .dbWrEn(dbWrEn), .dbWrAddr(dbWrAddr), .dbWrData(dbWrData), .flagWrEn(flagWrEn),
    .flagPort(flagPort), .flagCmd(flagCmd), .flagData(flagData),
    .replyValid(replyValid), .replyWord(replyWord), .replyLast(replyLast),
    .warmRestart(warmRestart), .blockDone(blockDone),
    .inputChunkIndex(inputChunkIndex), .outputChunkRequest(outputChunkRequest));

  // Free-running 125 MHz clock.
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Records every pulse and reply word the decoder produces.
  always @(posedge clk) begin
    if (dbWrEn === 1'b1) dbQ.push_back({dbWrAddr, dbWrData});
    if (flagWrEn === 1'b1) flagQ.push_back({7'h00, flagPort, flagCmd, flagData});
    if (replyValid === 1'b1) repQ.push_back(replyWord);
    if (replyLast === 1'b1) lastAt = repQ.size();
    if (warmRestart === 1'b1) warmN++;
    if (blockDone === 1'b1) doneN++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] nextIdx(input logic [7:0] i);
    return (i == 8'(WB)) ? 8'h01 : i + 8'h01;
  endfunction : nextIdx

  function automatic logic [31:0] dbEntry(input int bi, input int k);
    return {16'((bi - 1) * CHUNK + k - 1), blk[k]};
  endfunction : dbEntry

  // Expected reply word i; unused error slots and the spare tail read zero.
  function automatic logic [15:0] repExp(input int i);
    case (i)
      0: return ID_ERRLIST;
      1: return {8'h00, expReq};
      2: return 16'(p);
      3: return 16'(cnt);
      4: return 16'(st);
      default: return (i - 5 < cnt) ? errMem[p][st + i - 5] : 16'h0000;
    endcase
  endfunction : repExp

  task automatic fill(input int bi);
    blk[0] = 16'(bi);
    for (int i = 1; i <= CHUNK; i++) blk[i] = 16'($urandom);
  endtask : fill

  // Sends one block and checks the completion pulse and the index sequence.
  task automatic run_block(input logic slow);
    dbQ.delete();
    flagQ.delete();
    repQ.delete();
    warmN = 0;
    doneN = 0;
    lastAt = 0;
    host.send(blk, slow);
    repeat (72) @(posedge clk);
    #1;
    expReq = nextIdx(expReq);
    chk(32'(doneN), 32'h1, "block done count");
    chk(32'(outputChunkRequest), 32'(expReq), "write request");
    chk(32'(inputChunkIndex), 32'(expReq), "read index");
  endtask : run_block

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // Cuts a hang short well beyond the few thousand cycles the tests need.
  initial begin
    #(8 * 40000);
    bad_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    {nrst, cmdDone, donePort, doneCmd, doneCode} = '0;
    {errWrEn, errPort, errCmd, errValue} = '0;
    bad_count = 0;
    comparisons = 0;
    expReq = 8'h01;
    void'($urandom(32'hC18F));
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk(32'(outputChunkRequest), 32'h1, "request after reset");
    $display("test reset finished");
    // Data blocks at both ends of the index range, then a random one.
    for (int t = 0; t < 3; t++) begin
      id = (t == 0) ? 1 : (t == 1) ? WB : 2 + $urandom % 18;
      fill(id);
      run_block(t[0]);
      chk(32'(dbQ.size()), 32'(CHUNK), "db word count");
      for (int k = 1; k <= CHUNK; k++) chk(dbQ[k - 1], dbEntry(id, k), "db word");
    end
    $display("test data finished");
    // Null, out-of-range and cold-boot identifiers write nothing.
    for (int t = 0; t < 4; t++) begin
      fill(ign[t]);
      run_block(1'b0);
      chk(32'(dbQ.size() + flagQ.size() + repQ.size() + warmN), 32'h0, "ignored");
    end
    fill(ID_WARM);
    run_block(1'b1);
    chk(32'(warmN), 32'h1, "warm pulse");
    chk(32'(dbQ.size()), 32'h0, "warm no data");
    $display("test null and warm finished");
    // Enable with an out-of-list number first, then a count-60 disable.
    for (int t = 0; t < 2; t++) begin
      p = $urandom % 4;
      cnt = t ? 60 : 2 + $urandom % 58;
      fill(t ? ID_DISABLE : ID_ENABLE);
      blk[1] = 16'(p);
      blk[2] = 16'(cnt);
      expF.delete();
      // A block ends at word CHUNK, so numbers that would fall past it never exist.
      for (int i = 0; i < cnt && 3 + i <= CHUNK; i++) begin
        c = (t == 0 && i == 0) ? LEN : $urandom % LEN;
        blk[3 + i] = 16'(c);
        if (c < LEN) expF.push_back({7'h00, 2'(p), 7'(c), t ? FLAG_OFF : FLAG_ON});
      end
      run_block(t[0]);
      chk(32'(flagQ.size()), 32'(expF.size()), "flag count");
      foreach (expF[i]) chk(flagQ[i], expF[i], "flag write");
      chk(32'(repQ.size()), 32'h0, "no reply");
    end
    $display("test enable and disable finished");
    // Bad port, counts and range: nothing written, no reply.
    for (int t = 0; t < 6; t++) begin
      fill(bid[t]);
      blk[1] = 16'(bp[t]);
      blk[2] = 16'(bc[t]);
      blk[3] = 16'(bs[t]);
      run_block(1'b0);
      chk(32'(flagQ.size() + repQ.size()), 32'h0, "bad block");
    end
    $display("test bad control finished");
    // Error entries on two ports, so a port mix-up shows.
    for (int pp = 1; pp < 3; pp++) begin
      for (int ci = 0; ci < LEN; ci++) begin
        @(posedge clk);
        #1;
        errWrEn = 1'b1;
        errPort = 2'(pp);
        errCmd = 7'(ci);
        errValue = 16'($urandom);
        errMem[pp][ci] = errValue;
      end
    end
    @(posedge clk);
    #1;
    errWrEn = 1'b0;
    // Last possible window first, then a random one within the list.
    for (int t = 0; t < 2; t++) begin
      p = t ? 1 : 2;
      cnt = t ? 1 + $urandom % 50 : 50;
      st = t ? $urandom % (100 - cnt) : 49;
      fill(ID_ERRLIST);
      blk[1] = 16'(p);
      blk[2] = 16'(cnt);
      blk[3] = 16'(st);
      run_block(t[0]);
      chk(32'(repQ.size()), 32'h40, "reply length");
      chk(32'(lastAt), 32'h40, "reply last");
      for (int i = 0; i < 64; i++) chk(32'(repQ[i]), 32'(repExp(i)), "reply word");
    end
    $display("test error list finished");
    // Every enable code; only the one-shot code clears its flag.
    for (int code = 0; code < 8; code++) begin
      flagQ.delete();
      p = $urandom % 4;
      c = $urandom % LEN;
      cmdDone = 1'b1;
      doneCode = 3'(code);
      donePort = 2'(p);
      doneCmd = 7'(c);
      @(posedge clk);
      #1;
      cmdDone = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(32'(flagQ.size()), (code == 5) ? 32'h1 : 32'h0, "one-shot count");
      if (code == 5) chk(flagQ[0], {7'h00, 2'(p), 7'(c), FLAG_OFF}, "one-shot clear");
    end
    $display("test one-shot finished");
    end_of_test();
  end
endmodule : tb
